// *** hw/serial_port_strap_sampler.sv ***
// Serial port strap sampler: captures pair straps after reset, applies overrides
//
// Summary of operation
// - Width strap low selects one four-lane port; high selects two single-lane ports.
// - Width strap high runs the pair as independent single-lane ports n and n+1.
// - After capture, later strap changes are ignored; captured values kept.
// - Primary power-down low powers port n; port n+1 follows its own strap.
// - Primary power-down high powers down both ports of the pair.
// - Primary power-down governs all four lanes of the pair together.
// - Secondary strap powers port n+1 up when low, down when high.
// - In four-lane mode port n+1 is unused and held powered down.
// - Once the straps are captured a software field can override the primary power-down.
// - Once the straps are captured a separate software field can override the secondary power-down.
// - Strap pins are inputs normally; driven only in test mode.
// - Only ports 0 and 6 offer width selection; others single-lane only.
`timescale 1ns/1ns
`default_nettype none
module serial_port_strap_sampler import strap_cfg_pkg::*; #(
  parameter int PAIRS = NUM_PAIRS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [PAIRS-1:0] pair_width_strap_i,
  input wire logic [PAIRS-1:0] pair_primary_powerdown_strap_i,
  input wire logic [PAIRS-1:0] pair_secondary_powerdown_strap_i,
  output logic [PAIRS-1:0] pair_width_strap_o,
  output logic [PAIRS-1:0] pair_primary_powerdown_strap_o,
  output logic [PAIRS-1:0] pair_secondary_powerdown_strap_o,
  output logic [PAIRS-1:0] strap_oe,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic capture_done,
  output logic [PAIRS-1:0] wide_mode,
  output logic [2*PAIRS-1:0] port_powerdown,
  output logic [LANES_PER_PAIR*PAIRS-1:0] lane_powerdown
);
  // ==========================================================
  // Elaboration checks
  // Register map, status word and pair mask are laid out for the documented pair count
  if (PAIRS != NUM_PAIRS) begin : g_bad_pairs
    $error("PAIRS must equal the number of port pairs");
  end

  // Straps must be taken while the board still holds them
  if (CAPTURE_CYCLE >= STRAP_HOLD_CYCLES) begin : g_late_capture
    $error("Capture cycle lies outside the strap hold window");
  end

  // Both synchroniser stages must have filled before the straps are taken
  if (CAPTURE_CYCLE < SYNC_STAGES) begin : g_early_capture
    $error("Capture cycle precedes synchroniser settling");
  end

  // The capture counter is four bits and must reach its compare value
  if (CAPTURE_CYCLE != int'(CAPTURE_CNT)) begin : g_cnt_width
    $error("Capture cycle does not fit the capture counter");
  end

  // Status nibbles must leave the done bit free
  if (STATUS_FIELD_W * PAIRS > STATUS_DONE_BIT) begin : g_status_overlap
    $error("Status fields overlap the capture done bit");
  end

  // ==========================================================
  // Strap synchroniser
  logic [3*PAIRS-1:0] sync1_r;
  logic [3*PAIRS-1:0] sync2_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {pair_width_strap_i, pair_primary_powerdown_strap_i,
                  pair_secondary_powerdown_strap_i};
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // Capture sequencer
  cap_state_e state_r;
  cap_state_e state_nxt;
  logic [3:0] cnt_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CAP_RESET: state_nxt = CAP_WAIT;
      CAP_WAIT: begin
        if (cnt_r == CAPTURE_CNT) begin
          state_nxt = CAP_DONE;
        end
      end
      CAP_DONE: state_nxt = CAP_DONE;
      default: state_nxt = CAP_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= CAP_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= CNT_ZERO;
    // Counter stops once done, so it can never wrap into a second capture
    end else if (state_r != CAP_DONE) begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  logic capture_now;
  assign capture_now = (state_r == CAP_WAIT) && (cnt_r == CAPTURE_CNT);
  assign capture_done = (state_r == CAP_DONE);

  // ==========================================================
  // Captured straps, frozen once taken
  pair_strap_s [PAIRS-1:0] cap_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PAIRS; i++) begin
        cap_r[i] <= '{width_strap: WIDTH_RST, pri_pd_strap: PWRDN_RST, sec_pd_strap: PWRDN_RST};
      end
    end else if (capture_now) begin
      for (int i = 0; i < PAIRS; i++) begin
        cap_r[i].width_strap <= sync2_r[2*PAIRS+i];
        cap_r[i].pri_pd_strap <= sync2_r[PAIRS+i];
        cap_r[i].sec_pd_strap <= sync2_r[i];
      end
    end
  end

  // ==========================================================
  // Register bus slave
  pair_ovr_s [PAIRS-1:0] ovr_r;
  logic test_en_r;
  logic ack_r;
  logic err_r;
  logic [31:0] rdata_r;
  logic req;

  assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;

  // ==========================================================
  // Address decode
  function automatic logic is_ovr_addr(input logic [7:0] a);
    return (a >= ADDR_OVR_BASE) && (a < ADDR_OVR_BASE + 8'(REG_STRIDE*PAIRS)) &&
           (a[1:0] == 2'b00);
  endfunction : is_ovr_addr

  function automatic logic is_mapped(input logic [7:0] a);
    return is_ovr_addr(a) || (a == ADDR_STATUS) || (a == ADDR_TEST);
  endfunction : is_mapped

  logic [1:0] ovr_idx;
  assign ovr_idx = wb_adr_i[3:2];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ovr_r <= '0;
    end else if (req && wb_we_i && wb_sel_i[0] && is_ovr_addr(wb_adr_i) && capture_done) begin
      // Override writes are stored only once the straps have been captured; earlier writes are dropped
      ovr_r[ovr_idx].en_pri <= wb_dat_i[OVR_EN_PRI_BIT];
      ovr_r[ovr_idx].pri <= wb_dat_i[OVR_PRI_BIT];
      ovr_r[ovr_idx].en_sec <= wb_dat_i[OVR_EN_SEC_BIT];
      ovr_r[ovr_idx].sec <= wb_dat_i[OVR_SEC_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      test_en_r <= 1'h0;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_TEST) begin
      test_en_r <= wb_dat_i[TEST_EN_BIT];
    end
  end

  // Registered answer: one wait state, and a held request is not taken twice
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= req && is_mapped(wb_adr_i);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_r <= 1'h0;
    end else begin
      err_r <= req && !is_mapped(wb_adr_i);
    end
  end

  pair_cfg_s [PAIRS-1:0] cfg;

  // Read data is a snapshot taken at the take edge, so it stands with ack
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      rdata_r <= 32'h0000_0000;
      if (is_ovr_addr(wb_adr_i)) begin
        rdata_r[3:0] <= {ovr_r[ovr_idx].sec, ovr_r[ovr_idx].en_sec,
                         ovr_r[ovr_idx].pri, ovr_r[ovr_idx].en_pri};
      end else if (wb_adr_i == ADDR_STATUS) begin
        for (int i = 0; i < PAIRS; i++) begin
          rdata_r[STATUS_FIELD_W*i +: STATUS_FIELD_W] <= {cfg[i].port_n1_pd, cfg[i].port_n_pd,
                                                          cfg[i].wide_mode, cap_r[i].width_strap};
        end
        rdata_r[STATUS_DONE_BIT] <= capture_done;
      end else if (wb_adr_i == ADDR_TEST) begin
        rdata_r[TEST_EN_BIT] <= test_en_r;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdata_r;

  // ==========================================================
  // Per-pair decode
  for (genvar g = 0; g < PAIRS; g++) begin : g_pair
    pair_power_decode #(
      .WIDE_CAPABLE(WIDE_CAPABLE_MASK[g])
    ) u_decode (
      .cap(cap_r[g]),
      .ovr(ovr_r[g]),
      .cfg(cfg[g])
    );
  end

  // ==========================================================
  // Registered configuration outputs and test-mode pin drive
  // Ports come up powered down so nothing runs before the straps are known
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wide_mode <= '0;
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        wide_mode[i] <= cfg[i].wide_mode;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_powerdown <= '1;
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        port_powerdown[2*i] <= cfg[i].port_n_pd;
        port_powerdown[2*i+1] <= cfg[i].port_n1_pd;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lane_powerdown <= '1;
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        lane_powerdown[LANES_PER_PAIR*i +: LANES_PER_PAIR] <= cfg[i].lane_pd;
      end
    end
  end

  // Output enable follows the test bit one cycle late
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_oe <= '0;
    end else begin
      strap_oe <= {PAIRS{test_en_r}};
    end
  end

  // Pins drive back the captured values only in test mode, so the board sees them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pair_width_strap_o <= '0;
      pair_primary_powerdown_strap_o <= '0;
      pair_secondary_powerdown_strap_o <= '0;
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        pair_width_strap_o[i] <= cap_r[i].width_strap;
        pair_primary_powerdown_strap_o[i] <= cap_r[i].pri_pd_strap;
        pair_secondary_powerdown_strap_o[i] <= cap_r[i].sec_pd_strap;
      end
    end
  end
endmodule : serial_port_strap_sampler
`default_nettype wire

// *** pkg/strap_cfg_pkg.sv ***
// Constants and carrier types for the serial port strap sampler
`default_nettype none
package strap_cfg_pkg;
  localparam int NUM_PAIRS = 4;
  localparam int PORTS_PER_PAIR = 2;
  localparam int LANES_PER_PAIR = 4;
  localparam int CLK_PERIOD_NS = 10;
  // Board holds straps steady this many core cycles after reset release
  localparam int STRAP_HOLD_CYCLES = 10;
  // Capture well inside the hold window, after the two-stage synchroniser has settled
  localparam int CAPTURE_CYCLE = 4;
  localparam logic [3:0] CAPTURE_CNT = 4'(CAPTURE_CYCLE);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // Pairs whose width strap is honoured (pair 0 = ports 0/1, pair 3 = ports 6/7)
  localparam logic [NUM_PAIRS-1:0] WIDE_CAPABLE_MASK = 4'h9;
  // Reset values of captured straps (pull-down width, pull-up power-downs)
  localparam logic WIDTH_RST = 1'h0;
  localparam logic PWRDN_RST = 1'h1;
  // Register bus map
  localparam logic [7:0] ADDR_OVR_BASE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TEST = 8'h14;
  localparam int OVR_EN_PRI_BIT = 0;
  localparam int OVR_PRI_BIT = 1;
  localparam int OVR_EN_SEC_BIT = 2;
  localparam int OVR_SEC_BIT = 3;
  localparam int TEST_EN_BIT = 0;
  // Status word layout: one nibble per pair, done flag at the top
  localparam int STATUS_FIELD_W = 4;
  localparam int STATUS_DONE_BIT = 31;
  // Byte distance between per-pair override registers
  localparam int REG_STRIDE = 4;
  // Depth of the strap synchroniser
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CAP_RESET = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_DONE = 2'b10
  } cap_state_e;

  typedef struct packed {
    logic width_strap;
    logic pri_pd_strap;
    logic sec_pd_strap;
  } pair_strap_s;

  typedef struct packed {
    logic en_pri;
    logic pri;
    logic en_sec;
    logic sec;
  } pair_ovr_s;

  typedef struct packed {
    logic wide_mode;
    logic port_n_pd;
    logic port_n1_pd;
    logic [LANES_PER_PAIR-1:0] lane_pd;
  } pair_cfg_s;
endpackage : strap_cfg_pkg
`default_nettype wire

// *** hw/pair_power_decode.sv ***
// Combinational decode of one port pair's mode and power state
`timescale 1ns/1ns
`default_nettype none
module pair_power_decode import strap_cfg_pkg::*; #(
  parameter bit WIDE_CAPABLE = 1'b0
) (
  input wire pair_strap_s cap,
  input wire pair_ovr_s ovr,
  output pair_cfg_s cfg
);
  logic pri_pd;
  logic sec_pd;
  logic wide;

  always_comb begin
    wide = WIDE_CAPABLE && !cap.width_strap;
    pri_pd = ovr.en_pri ? ovr.pri : cap.pri_pd_strap;
    sec_pd = ovr.en_sec ? ovr.sec : cap.sec_pd_strap;
    cfg.wide_mode = wide;
    cfg.port_n_pd = pri_pd;
    // Unused second port is forced off in wide mode even if the board got it wrong
    cfg.port_n1_pd = pri_pd || sec_pd || wide;
    cfg.lane_pd = {LANES_PER_PAIR{pri_pd}};
  end
endmodule : pair_power_decode
`default_nettype wire

// *** verification/strap_board_model.sv ***
// Board model: strap tie-offs with hold window and shared pin levels
`timescale 1ns/1ns
`default_nettype none
module strap_board_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] cmd,
  input wire logic [3:0] oe,
  input wire logic [11:0] dev,
  output logic [11:0] pin
);
  logic [11:0] held_r;
  logic [3:0] cnt_r;
  logic [11:0] oe_all;
  always_ff @(posedge ref_clk) begin
    if (!nrst) held_r <= cmd;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cnt_r <= 4'h0;
    else if (cnt_r != 4'hA) cnt_r <= cnt_r + 4'h1;
  end
  assign oe_all = {oe, oe, oe};
  // Tie-offs frozen through the hold window, then they follow the bench
  assign pin = (oe_all & dev) | (~oe_all & ((cnt_r != 4'hA) ? held_r : cmd));
endmodule : strap_board_model
`default_nettype wire

// *** verification/strap_sampler_sva.sv ***
// Port checker for the strap sampler
`timescale 1ns/1ns
`default_nettype none
module strap_sampler_chk import strap_cfg_pkg::*; #(
  parameter int PAIRS = NUM_PAIRS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [PAIRS-1:0] strap_oe,
  input wire logic capture_done,
  input wire logic [PAIRS-1:0] wide_mode,
  input wire logic [2*PAIRS-1:0] port_powerdown,
  input wire logic [LANES_PER_PAIR*PAIRS-1:0] lane_powerdown
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic [7:0] pd = port_powerdown;
  logic test_wr_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) test_wr_r <= 1'b0;
    else test_wr_r <= wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o & (wb_adr_i == ADDR_TEST);
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence reply_s;
    (wb_ack_o != wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  bus_reply_a: assert property (req_s |=> reply_s) else $error("bus reply wrong");
  lane_join_a: assert property (lane_powerdown == {{4{pd[6]}}, {4{pd[4]}}, {4{pd[2]}}, {4{pd[0]}}})
    else $error("lane power mismatch");
  both_down_a: assert property (((pd[6:0] & ~pd[7:1]) & 7'h55) == 7'h00)
    else $error("port n+1 up while port n down");
  narrow_pair_a: assert property ((wide_mode & ~WIDE_CAPABLE_MASK) == 4'h0)
    else $error("wide mode on narrow pair");
  wide_sec_a: assert property ((wide_mode & ~{pd[7], pd[5], pd[3], pd[1]}) == 4'h0)
    else $error("unused port powered");
  done_hold_a: assert property (capture_done |=> capture_done) else $error("done fell");
  width_frozen_a: assert property (capture_done && $past(capture_done) |=> $stable(wide_mode))
    else $error("width changed after capture");
  oe_cause_a: assert property ($changed(strap_oe) |-> $past(test_wr_r))
    else $error("pin drive changed without test write");
endmodule : strap_sampler_chk
bind serial_port_strap_sampler strap_sampler_chk #(.PAIRS(PAIRS)) i_strap_sampler_chk (
  .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .strap_oe(strap_oe), .capture_done(capture_done), .wide_mode(wide_mode),
  .port_powerdown(port_powerdown), .lane_powerdown(lane_powerdown));
`default_nettype wire

// *** verification/serial_port_strap_sampler_tb.sv ***
// Self-checking bench for the serial port strap sampler
`timescale 1ns/1ns
`default_nettype none
module serial_port_strap_sampler_tb import strap_cfg_pkg::*; ();
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [11:0] cmd = 12'h000;
  logic [11:0] cap, dev, pin;
  logic [31:0] rdat, rd;
  logic ack, berr, done, e;
  logic [3:0] oe, wide;
  logic [7:0] pd;
  logic [15:0] lanes;
  logic [3:0] ovr [4];
  int err_count = 0;
  int tests_run = 0;
  int seed = 66;
  int i, k;
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  serial_port_strap_sampler i_serial_port_strap_sampler (.ref_clk(ref_clk), .nrst(nrst),
    .pair_width_strap_i(pin[11:8]), .pair_primary_powerdown_strap_i(pin[7:4]),
    .pair_secondary_powerdown_strap_i(pin[3:0]), .pair_width_strap_o(dev[11:8]),
    .pair_primary_powerdown_strap_o(dev[7:4]), .pair_secondary_powerdown_strap_o(dev[3:0]),
    .strap_oe(oe), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(berr),
    .capture_done(done), .wide_mode(wide), .port_powerdown(pd), .lane_powerdown(lanes));
  strap_board_model i_strap_board_model (.ref_clk(ref_clk), .nrst(nrst), .cmd(cmd), .oe(oe),
    .dev(dev), .pin(pin));
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic fail_out;
    err_count++;
    finish_test();
  endtask : fail_out
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 28'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && berr !== 1'b1 && n < 20);
    if (ack !== 1'b1 && berr !== 1'b1) fail_out();
    rd = rdat;
    e = berr;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // Returns {wide_mode, port_powerdown} from straps and the bench's override copy
  function automatic logic [11:0] exp_cfg(input logic [11:0] s);
    logic [11:0] r;
    logic pn;
    r = 12'h000;
    for (int j = 0; j < 4; j++) begin
      r[8+j] = WIDE_CAPABLE_MASK[j] & ~s[8+j];
      pn = ovr[j][0] ? ovr[j][1] : s[4+j];
      r[2*j] = pn;
      r[2*j+1] = pn | r[8+j] | (ovr[j][2] ? ovr[j][3] : s[j]);
    end
    return r;
  endfunction : exp_cfg
  // All four lanes of a pair follow the pair's primary power-down
  function automatic logic [15:0] exp_lanes(input logic [11:0] s);
    logic [11:0] c;
    logic [15:0] l;
    c = exp_cfg(s);
    l = 16'h0000;
    for (int j = 0; j < 4; j++) l[4*j +: 4] = {4{c[2*j]}};
    return l;
  endfunction : exp_lanes
  // Status word: per pair {port n+1 down, port n down, wide, width strap}, done on top
  function automatic logic [31:0] exp_status(input logic [11:0] s);
    logic [11:0] c;
    logic [31:0] w;
    c = exp_cfg(s);
    w = 32'h8000_0000;
    for (int j = 0; j < 4; j++) w[4*j +: 4] = {c[2*j+1], c[2*j], c[8+j], s[8+j]};
    return w;
  endfunction : exp_status
  initial begin
    for (k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      nrst <= 1'b0;
      cmd <= (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : 12'($random(seed));
      repeat (5) @(posedge ref_clk);
      cap = cmd;
      for (i = 0; i < 4; i++) ovr[i] = 4'h0;
      nrst <= 1'b1;
      wb(1'b1, ADDR_OVR_BASE, 4'h3);
      for (i = 0; i < 30 && done !== 1'b1; i++) @(posedge ref_clk);
      if (done !== 1'b1) fail_out();
      repeat (2) @(posedge ref_clk);
      chk("cfg", {20'h0, exp_cfg(cap)}, {20'h0, wide, pd});
      chk("lanes", {16'h0, exp_lanes(cap)}, {16'h0, lanes});
      chk("oe off", 32'h0, {28'h0, oe});
      cmd <= ~cap;
      repeat (12) @(posedge ref_clk);
      chk("frozen", {20'h0, exp_cfg(cap)}, {20'h0, wide, pd});
      wb(1'b0, ADDR_OVR_BASE, 4'h0);
      chk("ovr reset", 32'h0, rd);
      for (i = 0; i < 4; i++) begin
        ovr[i] = 4'($random(seed));
        wb(1'b1, ADDR_OVR_BASE + 8'(4 * i), ovr[i]);
      end
      repeat (2) @(posedge ref_clk);
      chk("ovr", {20'h0, exp_cfg(cap)}, {20'h0, wide, pd});
      chk("ovr lanes", {16'h0, exp_lanes(cap)}, {16'h0, lanes});
      wb(1'b0, ADDR_STATUS, 4'h0);
      chk("status", exp_status(cap), rd);
      wb(1'b0, 8'h20, 4'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      wb(1'b1, ADDR_TEST, 4'h1);
      repeat (2) @(posedge ref_clk);
      chk("oe", 32'hF, {28'h0, oe});
      chk("pins", {20'h0, cap}, {20'h0, pin});
      wb(1'b1, ADDR_TEST, 4'h0);
      repeat (2) @(posedge ref_clk);
      chk("oe idle", 32'h0, {28'h0, oe});
      chk("pins idle", {20'h0, ~cap}, {20'h0, pin});
    end
    finish_test();
  end
endmodule : serial_port_strap_sampler_tb
`default_nettype wire
